// *** rx_framer_pkg.sv ***
// Constants, register map and carrier types of the receive message framer
package rx_framer_pkg;

  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  localparam int ADDR_W = 9;
  localparam logic [8:0] REG_STATUS = 9'h000;
  localparam logic [8:0] REG_CONTROL = 9'h001;
  localparam logic [8:0] REG_START_CHAR = 9'h002;
  localparam logic [8:0] REG_END_CHAR = 9'h003;
  localparam logic [8:0] REG_IDLE_HI = 9'h004;
  localparam logic [8:0] REG_IDLE_LO = 9'h005;
  localparam logic [8:0] REG_TIMEOUT_HI = 9'h006;
  localparam logic [8:0] REG_TIMEOUT_LO = 9'h007;
  localparam logic [8:0] REG_MAX_COUNT = 9'h008;
  localparam logic [8:0] REG_RX_CHAR = 9'h009;
  localparam logic [8:0] REG_RX_PARITY = 9'h00A;
  localparam logic [8:0] REG_COMMAND = 9'h00B;
  localparam logic [8:0] REG_RX_COUNT = 9'h00C;
  localparam logic [8:0] REG_MSG_BUF = 9'h100;
  localparam int CMD_RECEIVE_BIT = 0;
  localparam int PARITY_ERR_BIT = 0;

  // ----------------------------------------------------------------
  // Status byte layout and values
  // ----------------------------------------------------------------
  localparam int STS_N = 7;
  localparam int STS_R = 6;
  localparam int STS_E = 5;
  localparam int STS_T = 2;
  localparam int STS_C = 1;
  localparam int STS_P = 0;
  localparam logic [7:0] STATUS_RESET = 8'h80;
  localparam logic [7:0] STATUS_BUSY = 8'h00;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [15:0] MS_ZERO = 16'h0000;
  localparam logic [15:0] MS_MAX = 16'hFFFF;

  // ----------------------------------------------------------------
  // Event numbers
  // ----------------------------------------------------------------
  localparam logic [7:0] EVT_CHAR_P0 = 8'h08;
  localparam logic [7:0] EVT_CHAR_P1 = 8'h19;
  localparam logic [7:0] EVT_MSG_P0 = 8'h17;
  localparam logic [7:0] EVT_MSG_P1 = 8'h18;

  // ----------------------------------------------------------------
  // Timing and sizes
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_PERIOD_MS = 1;
  localparam int NS_PER_MS = 1000000;
  localparam int CYCLES_PER_MS = (TICK_PERIOD_MS * NS_PER_MS) / CLK_PERIOD_NS;
  localparam int MAX_CHARS = 255;
  localparam int BUF_DEPTH = MAX_CHARS + 1;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] data;
    logic parity_err;
    logic overrun;
    logic port;
  } rx_char_t;

  typedef struct packed {
    logic enable;
    logic use_start_char;
    logic use_end_char;
    logic use_idle;
    logic msg_timer;
    logic use_timeout;
    logic [1:0] rsvd;
  } rx_ctrl_t;

  typedef enum logic [1:0] {
    ST_OFF = 2'b00,
    ST_WAIT_IDLE = 2'b01,
    ST_WAIT_START = 2'b10,
    ST_RECV = 2'b11
  } rx_state_t;

endpackage

// *** serial_receive_message_framer.sv ***
// Receive message framer with shared per-character buffer and register port
//
// Chosen here: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
module serial_receive_message_framer #(
  parameter logic PORT_ID = 1'b0,
  parameter int TICK_CYCLES = rx_framer_pkg::CYCLES_PER_MS
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [rx_framer_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic rx_valid,
  input wire rx_framer_pkg::rx_char_t rx_char,
  output logic char_event,
  output logic [7:0] char_event_num,
  output logic msg_done,
  output logic [7:0] msg_event_num,
  output logic rx_active
);
  import rx_framer_pkg::*;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  rx_ctrl_t ctrl_q;
  logic [7:0] start_chr_q;
  logic [7:0] end_chr_q;
  logic [15:0] idle_q;
  logic [15:0] tmo_q;
  logic [7:0] maxc_q;
  logic [7:0] rx_buf_q;
  logic parity_q;
  logic [7:0] status_q;
  logic [7:0] count_q;
  rx_state_t state_q;
  logic [7:0] msg_buf [BUF_DEPTH];
  logic [31:0] div_q;
  logic tick_q;
  logic [15:0] idle_cnt_q;
  logic [15:0] tmo_cnt_q;
  logic [7:0] rdata_q;
  logic char_event_q;
  logic [7:0] char_event_num_q;
  logic msg_done_q;
  logic [7:0] msg_event_num_q;
  logic rx_active_q;

  logic op_go;
  logic my_char;
  logic good_char;
  logic bad_char;
  logic [7:0] count_inc;
  logic is_end_char;
  logic at_max;
  logic idle_done;
  logic tmo_done;

  assign op_go = reg_wr && (reg_addr == REG_COMMAND) && reg_wdata[CMD_RECEIVE_BIT];
  assign my_char = rx_valid && (rx_char.port == PORT_ID);
  assign bad_char = my_char && (rx_char.parity_err || rx_char.overrun);
  assign good_char = my_char && !bad_char;
  assign count_inc = count_q + 8'h01;
  assign is_end_char = ctrl_q.use_end_char && (rx_char.data == end_chr_q);
  assign at_max = (count_inc == maxc_q);
  assign idle_done = (idle_cnt_q >= idle_q);
  assign tmo_done = ctrl_q.use_timeout && (count_q != BYTE_ZERO) && (tmo_cnt_q > tmo_q);

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ctrl_q <= '0;
      start_chr_q <= BYTE_ZERO;
      end_chr_q <= BYTE_ZERO;
      idle_q <= MS_ZERO;
      tmo_q <= MS_ZERO;
      maxc_q <= BYTE_ZERO;
    end else if (reg_wr) begin
      if (reg_addr == REG_CONTROL) begin
        ctrl_q <= {reg_wdata[7:2], 2'b00};
      end else if (reg_addr == REG_START_CHAR) begin
        start_chr_q <= reg_wdata;
      end else if (reg_addr == REG_END_CHAR) begin
        end_chr_q <= reg_wdata;
      end else if (reg_addr == REG_IDLE_HI) begin
        idle_q[15:8] <= reg_wdata;
      end else if (reg_addr == REG_IDLE_LO) begin
        idle_q[7:0] <= reg_wdata;
      end else if (reg_addr == REG_TIMEOUT_HI) begin
        tmo_q[15:8] <= reg_wdata;
      end else if (reg_addr == REG_TIMEOUT_LO) begin
        tmo_q[7:0] <= reg_wdata;
      end else if (reg_addr == REG_MAX_COUNT) begin
        maxc_q <= reg_wdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // Register reads, one cycle after the strobe
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rdata_q <= BYTE_ZERO;
    end else if (reg_rd) begin
      if (reg_addr == REG_STATUS) begin
        rdata_q <= status_q;
      end else if (reg_addr == REG_CONTROL) begin
        rdata_q <= ctrl_q;
      end else if (reg_addr == REG_START_CHAR) begin
        rdata_q <= start_chr_q;
      end else if (reg_addr == REG_END_CHAR) begin
        rdata_q <= end_chr_q;
      end else if (reg_addr == REG_IDLE_HI) begin
        rdata_q <= idle_q[15:8];
      end else if (reg_addr == REG_IDLE_LO) begin
        rdata_q <= idle_q[7:0];
      end else if (reg_addr == REG_TIMEOUT_HI) begin
        rdata_q <= tmo_q[15:8];
      end else if (reg_addr == REG_TIMEOUT_LO) begin
        rdata_q <= tmo_q[7:0];
      end else if (reg_addr == REG_MAX_COUNT) begin
        rdata_q <= maxc_q;
      end else if (reg_addr == REG_RX_CHAR) begin
        rdata_q <= rx_buf_q;
      end else if (reg_addr == REG_RX_PARITY) begin
        // Reserved bits of the parity byte read as zero
        rdata_q <= {7'h00, parity_q};
      end else if (reg_addr == REG_RX_COUNT) begin
        rdata_q <= count_q;
      end else if (reg_addr[8]) begin
        rdata_q <= msg_buf[reg_addr[7:0]];
      end else begin
        rdata_q <= BYTE_ZERO;
      end
    end else begin
      rdata_q <= BYTE_ZERO;
    end
  end

  // ----------------------------------------------------------------
  // Millisecond tick
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      div_q <= 32'h00000000;
      tick_q <= 1'b0;
    end else if (div_q == 32'(TICK_CYCLES - 1)) begin
      div_q <= 32'h00000000;
      tick_q <= 1'b1;
    end else begin
      div_q <= div_q + 32'h00000001;
      tick_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Idle line and timeout counters, saturating
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      idle_cnt_q <= MS_ZERO;
    end else if (my_char || op_go) begin
      idle_cnt_q <= MS_ZERO;
    end else if (tick_q && (idle_cnt_q != MS_MAX)) begin
      idle_cnt_q <= idle_cnt_q + 16'h0001;
    end
  end

  // Inter-character mode restarts on every character, message mode only on the first
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      tmo_cnt_q <= MS_ZERO;
    end else if (op_go || state_q != ST_RECV) begin
      tmo_cnt_q <= MS_ZERO;
    end else if (my_char && (count_q == BYTE_ZERO || !ctrl_q.msg_timer)) begin
      tmo_cnt_q <= MS_ZERO;
    end else if (tick_q && count_q != BYTE_ZERO && tmo_cnt_q != MS_MAX) begin
      tmo_cnt_q <= tmo_cnt_q + 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // Shared per-character buffer, loaded for either port
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rx_buf_q <= BYTE_ZERO;
      parity_q <= 1'b0;
      char_event_q <= 1'b0;
      char_event_num_q <= EVT_CHAR_P0;
    end else begin
      char_event_q <= rx_valid;
      if (rx_valid) begin
        // Data lands with the event pulse so a handler never sees stale bytes
        rx_buf_q <= rx_char.data;
        parity_q <= rx_char.parity_err;
        char_event_num_q <= rx_char.port ? EVT_CHAR_P1 : EVT_CHAR_P0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Message store
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (good_char && (state_q == ST_RECV || (state_q == ST_WAIT_START && rx_char.data == start_chr_q))) begin
      msg_buf[count_q] <= rx_char.data;
    end
  end

  // ----------------------------------------------------------------
  // Framing state machine
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_q <= ST_OFF;
      status_q <= STATUS_RESET;
      count_q <= BYTE_ZERO;
      msg_done_q <= 1'b0;
    end else begin
      msg_done_q <= 1'b0;
      if (op_go) begin
        msg_done_q <= !ctrl_q.enable || state_q != ST_OFF;
        if (!ctrl_q.enable) begin
          state_q <= ST_OFF;
          status_q <= 8'h01 << STS_N;
        end else if (!(ctrl_q.use_start_char || ctrl_q.use_idle) || maxc_q == BYTE_ZERO) begin
          state_q <= ST_OFF;
          status_q <= 8'h01 << STS_R;
        end else begin
          status_q <= STATUS_BUSY;
          count_q <= BYTE_ZERO;
          state_q <= ctrl_q.use_idle ? ST_WAIT_IDLE : ST_WAIT_START;
        end
      end else if (state_q != ST_OFF && bad_char) begin
        state_q <= ST_OFF;
        status_q <= 8'h01 << STS_P;
        msg_done_q <= 1'b1;
      end else begin
        case (state_q)
          ST_WAIT_IDLE: begin
            if (!my_char && idle_done) begin
              state_q <= ctrl_q.use_start_char ? ST_WAIT_START : ST_RECV;
            end
          end
          ST_WAIT_START: begin
            if (good_char && rx_char.data == start_chr_q) begin
              count_q <= count_inc;
              if (is_end_char || at_max) begin
                state_q <= ST_OFF;
                status_q <= {2'b00, is_end_char, 2'b00, 1'b0, at_max, 1'b0};
                msg_done_q <= 1'b1;
              end else begin
                state_q <= ST_RECV;
              end
            end else if (good_char && ctrl_q.use_idle) begin
              // Idle must precede the start character, so look for idle again
              state_q <= ST_WAIT_IDLE;
            end
          end
          ST_RECV: begin
            if (good_char) begin
              count_q <= count_inc;
              if (is_end_char || at_max) begin
                state_q <= ST_OFF;
                status_q <= {2'b00, is_end_char, 2'b00, 1'b0, at_max, 1'b0};
                msg_done_q <= 1'b1;
              end
            end else if (tmo_done) begin
              state_q <= ST_OFF;
              status_q <= 8'h01 << STS_T;
              msg_done_q <= 1'b1;
            end
          end
          default: begin
            state_q <= ST_OFF;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Event outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      msg_event_num_q <= PORT_ID ? EVT_MSG_P1 : EVT_MSG_P0;
      rx_active_q <= 1'b0;
    end else begin
      msg_event_num_q <= PORT_ID ? EVT_MSG_P1 : EVT_MSG_P0;
      rx_active_q <= (state_q != ST_OFF);
    end
  end

  assign reg_rdata = rdata_q;
  assign char_event = char_event_q;
  assign char_event_num = char_event_num_q;
  assign msg_done = msg_done_q;
  assign msg_event_num = msg_event_num_q;
  assign rx_active = rx_active_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_idle_expires;
    state_q == ST_WAIT_IDLE && idle_done && !my_char && !op_go;
  endsequence

  sequence s_enters_start_wait;
    state_q == ST_WAIT_START;
  endsequence

  AST_DISABLE: assert property (@(posedge clk) disable iff (reset)
    op_go && !ctrl_q.enable |=> state_q == ST_OFF && status_q[STS_N] && msg_done_q)
    else $error("disabled receive did not report user disable");

  AST_START_CHAR: assert property (@(posedge clk) disable iff (reset)
    state_q == ST_WAIT_START && good_char && !op_go && rx_char.data != start_chr_q |=> state_q != ST_RECV)
    else $error("message started without start character");

  AST_END_CHAR: assert property (@(posedge clk) disable iff (reset)
    state_q == ST_RECV && good_char && !op_go && is_end_char |=> status_q[STS_E] && msg_done_q && state_q == ST_OFF)
    else $error("end character did not end message");

  AST_IDLE_THEN_START: assert property (@(posedge clk) disable iff (reset)
    s_idle_expires ##0 ctrl_q.use_start_char |=> s_enters_start_wait)
    else $error("idle line did not lead to start character wait");

  AST_IDLE_FIRST: assert property (@(posedge clk) disable iff (reset)
    s_idle_expires ##0 !ctrl_q.use_start_char |=> state_q == ST_RECV && count_q == BYTE_ZERO)
    else $error("idle line did not open a message");

  AST_TIMEOUT: assert property (@(posedge clk) disable iff (reset)
    state_q == ST_RECV && tmo_done && !my_char && !op_go |=> status_q == (8'h01 << STS_T) && msg_done_q)
    else $error("timeout did not terminate reception");

  AST_MSG_TIMER: assert property (@(posedge clk) disable iff (reset)
    state_q == ST_RECV && count_q != BYTE_ZERO && ctrl_q.msg_timer && my_char && !op_go && !tick_q
      |=> tmo_cnt_q == $past(tmo_cnt_q))
    else $error("message timer restarted on a character");

  AST_MAX_COUNT: assert property (@(posedge clk) disable iff (reset)
    state_q == ST_RECV && good_char && !op_go && at_max |=> status_q[STS_C] && count_q == maxc_q)
    else $error("maximum count did not end message");

  AST_ABORT: assert property (@(posedge clk) disable iff (reset)
    state_q != ST_OFF && bad_char && !op_go |=> state_q == ST_OFF && status_q == (8'h01 << STS_P))
    else $error("bad character did not abort reception");

  AST_CHAR_EVENT: assert property (@(posedge clk) disable iff (reset)
    rx_valid |=> char_event_q && rx_buf_q == $past(rx_char.data) && parity_q == $past(rx_char.parity_err)
      && char_event_num_q == ($past(rx_char.port) ? EVT_CHAR_P1 : EVT_CHAR_P0))
    else $error("character event without its data");

  AST_STATUS_BUSY: assert property (@(posedge clk) disable iff (reset)
    (state_q == ST_OFF) == (status_q != STATUS_BUSY))
    else $error("status byte disagrees with activity");

  AST_TICK_SPACING: assert property (@(posedge clk) disable iff (reset)
    tick_q |=> !tick_q [*2])
    else $error("millisecond tick too frequent");

endmodule

// *** remote_char_sender.sv ***
// Model of the remote serial device that sends characters to the framer
`timescale 1ns/1ps
module remote_char_sender (
  input wire logic clk,
  output logic rx_valid,
  output rx_framer_pkg::rx_char_t rx_char
);
  import rx_framer_pkg::*;

  initial begin
    rx_valid = 1'b0;
    rx_char = '1;
  end

  // One character per call; between pulses the line shows the inverse of the
  // last character, so sampling outside rx_valid never matches by luck
  task automatic send(input logic [7:0] d, input logic pe, input logic ov, input logic pt);
    @(posedge clk);
    rx_valid <= 1'b1;
    rx_char <= {d, pe, ov, pt};
    @(posedge clk);
    rx_valid <= 1'b0;
    rx_char <= ~rx_char;
  endtask
endmodule

// *** testbench.sv ***
// Self-checking testbench of the receive message framer
`timescale 1ns/1ps
module testbench;
  import rx_framer_pkg::*;
  // Short tick keeps millisecond figures to a few cycles
  localparam int TICK = 5;
  logic clk;
  logic reset;
  logic reg_wr;
  logic reg_rd;
  logic rx_valid;
  logic char_event;
  logic msg_done;
  logic rx_active;
  logic [ADDR_W-1:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic [7:0] char_event_num;
  logic [7:0] msg_event_num;
  logic [7:0] v;
  logic [7:0] lastc;
  rx_char_t rx_char;
  int n_errors, checks;
  logic [7:0] q[$];
  logic [23:0] ctab[3] = '{24'h600A80, 24'hA00A40, 24'hE00040};

  serial_receive_message_framer #(
    .PORT_ID(1'b0),
    .TICK_CYCLES(TICK)
  ) dut (
    .clk(clk),
    .reset(reset),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .rx_valid(rx_valid),
    .rx_char(rx_char),
    .char_event(char_event),
    .char_event_num(char_event_num),
    .msg_done(msg_done),
    .msg_event_num(msg_event_num),
    .rx_active(rx_active)
  );
  remote_char_sender snd (
    .clk(clk),
    .rx_valid(rx_valid),
    .rx_char(rx_char)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic close_out();
    if (n_errors == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [8:0] a, input logic [7:0] e, input string nm);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(nm, e, reg_rdata);
  endtask

  task automatic op(input logic [7:0] c, input logic [7:0] mx);
    wr(REG_CONTROL, c);
    wr(REG_MAX_COUNT, mx);
    wr(REG_COMMAND, 8'h01);
    q.delete();
  endtask

  task automatic tx(input logic [7:0] d, input logic pe = 1'b0, input logic ov = 1'b0,
                    input logic pt = 1'b0, input logic dn = 1'b0);
    snd.send(d, pe, ov, pt);
    lastc = d;
    #1;
    chk("char_event", 8'h01, {7'h0, char_event});
    chk("char_event_num", pt ? EVT_CHAR_P1 : EVT_CHAR_P0, char_event_num);
    chk("msg_done", {7'h0, dn}, {7'h0, msg_done});
    if (dn) chk("msg_event_num", EVT_MSG_P0, msg_event_num);
    rd(REG_RX_CHAR, d, "rx_char_buffer");
    rd(REG_RX_PARITY, {7'h0, pe}, "rx_parity_status");
  endtask

  task automatic wait_done(input int lim);
    int i;
    for (i = 0; i < lim && msg_done !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    chk("msg_done_wait", 8'h01, {7'h0, msg_done});
  endtask

  // Random payload stays clear of the start and end characters
  function automatic logic [7:0] rb();
    return 8'h40 | 8'($urandom & 32'h3F);
  endfunction

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    reset = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = '0;
    reg_wdata = 8'h00;
    n_errors = 0;
    checks = 0;
    v = 8'($urandom(32'h7af9));
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    rd(REG_STATUS, STATUS_RESET, "status");
    for (int a = 1; a <= 8; a++) begin
      v = rb();
      rd(ADDR_W'(a), 8'h00, "config_reset");
      wr(ADDR_W'(a), v);
      rd(ADDR_W'(a), a == 1 ? v & 8'hFC : v, "config_readback");
    end
    wr(REG_START_CHAR, 8'h3C);
    wr(REG_END_CHAR, 8'h0D);
    foreach (ctab[i]) begin
      op(ctab[i][23:16], ctab[i][15:8]);
      rd(REG_STATUS, ctab[i][7:0], "status_refused");
      chk("rx_active", 8'h00, {7'h0, rx_active});
    end
    op(8'hE0, 8'd20);
    // Enable is sampled only at issue, so clearing it now must not matter
    wr(REG_CONTROL, 8'h60);
    tx(.d(8'h41));
    rd(REG_RX_COUNT, 8'h00, "rx_count");
    q.push_back(8'h3C);
    tx(.d(8'h3C));
    for (int i = 0; i < 3; i++) begin
      q.push_back(rb());
      tx(.d(q[$]));
    end
    tx(.d(8'h3C), .pt(1'b1));
    rd(REG_RX_COUNT, 8'h04, "rx_count");
    chk("rx_active", 8'h01, {7'h0, rx_active});
    rd(REG_STATUS, STATUS_BUSY, "status");
    q.push_back(8'h0D);
    tx(.d(8'h0D), .dn(1'b1));
    rd(REG_STATUS, 8'h20, "status");
    chk("rx_active", 8'h00, {7'h0, rx_active});
    foreach (q[i]) rd(ADDR_W'(REG_MSG_BUF + i), q[i], "msg_buffer");
    for (int k = 0; k < 2; k++) begin
      v = k ? 8'hFF : 8'(2 + $urandom % 5);
      op(8'hC0, v);
      tx(.d(8'h3C));
      for (int i = 1; i < v; i++) tx(.d(rb()), .dn(i == v - 1));
      rd(REG_STATUS, 8'h02, "status");
    end
    wr(REG_TIMEOUT_HI, 8'h00);
    wr(REG_TIMEOUT_LO, 8'h02);
    for (int m = 0; m < 2; m++) begin
      op(8'hC4 | 8'(m << 3), 8'd50);
      snd.send(8'h3C, 1'b0, 1'b0, 1'b0);
      repeat (5) begin
        repeat (3) @(posedge clk);
        snd.send(rb(), 1'b0, 1'b0, 1'b0);
      end
      rd(REG_STATUS, m ? 8'h04 : 8'h00, "status");
      if (m == 0) begin
        wait_done(80);
        rd(REG_STATUS, 8'h04, "status");
      end
    end
    wr(REG_IDLE_HI, 8'h00);
    wr(REG_IDLE_LO, 8'h03);
    for (int x = 0; x < 2; x++) begin
      op(x ? 8'hF0 : 8'hB0, 8'd20);
      tx(.d(8'h3C));
      rd(REG_RX_COUNT, 8'h00, "rx_count");
      repeat (25) @(posedge clk);
      q.push_back(x ? 8'h3C : rb());
      tx(.d(q[0]));
      rd(REG_RX_COUNT, 8'h01, "rx_count");
      tx(.d(8'h0D), .dn(1'b1));
      rd(ADDR_W'(REG_MSG_BUF), q[0], "msg_buffer");
    end
    for (int k = 0; k < 2; k++) begin
      op(8'hE0, 8'd20);
      tx(.d(8'h3C));
      tx(.d(rb()), .pe(k == 0), .ov(k == 1), .dn(1'b1));
      rd(REG_STATUS, 8'h01, "status");
    end
    wr(REG_RX_CHAR, 8'hAA);
    wr(REG_STATUS, 8'h00);
    rd(REG_RX_CHAR, lastc, "rx_char_buffer");
    rd(REG_STATUS, 8'h01, "status");
    rd(9'h0FF, 8'h00, "unmapped");
    close_out();
  end

  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    close_out();
  end
endmodule
